// ===== hw/isf_core.sv
// What this block does
// R1 - Falling external pin edge sets external flag
// R2 - External service calls 04h, clears flag, global
// R3 - Timer 0 overflow flag; service calls 08h
// R4 - Timer 1 works alike, enable bit3 flag6
// R5 - Full stack blocks acknowledge, flag stays pending
// R6 - Entry and call push program counter only
// R7 - In service, hold until return or re-enable
// R8 - Return-from-irq pops and sets global enable
// R9 - Sample between phase pulses, service on second
// R10 - Priority external, timer 0, timer 1
// R11 - Bits 0..2 global, external, timer 0 enables
// R12 - Flags stay set until serviced or cleared
// R13 - Interrupt control bit 7 reads zero
// R14 - Status writes change only four ALU flags
// R15 - Carry from add, no-borrow, rotate-through
// R16 - Half carry from low nibble
// R17 - Zero flag on zero result
// R18 - Overflow when carries in, out differ
// R19 - Powerdown cleared by watchdog clear, set halt
// R20 - Timeout cleared by clear or halt, set by watchdog
// R21 - Full eight-bit ALU operation set
// R22 - Pre-set flag disables that source's wake
// R23 - Reset clears all enables and flags
//
// Register access over Wishbone is this design's own decision.
`timescale 1ns/1ps
module isf_core (
  input  wire logic       sys_clk,
  input  wire logic       arst_n,
  input  wire logic [7:0] wb_adr_i,
  input  wire logic [31:0] wb_dat_i,
  output logic      [31:0] wb_dat_o,
  input  wire logic       wb_we_i,
  input  wire logic [3:0] wb_sel_i,
  input  wire logic       wb_cyc_i,
  input  wire logic       wb_stb_i,
  output logic            wb_ack_o,
  input  wire logic       ext_irq_pin,
  input  wire logic       tmr0_ovf,
  input  wire logic       tmr1_ovf,
  output logic            irq_call,
  output logic      [7:0] irq_vector,
  output logic            pc_push,
  output logic            pc_pop,
  output logic            wake_req
);
  // Bus request packed for decode
  isf_pkg::isf_req_s req;
  logic              wr_en;
  logic              rd_en;
  logic [7:0]        idx;
  assign idx = wb_adr_i >> isf_pkg::IDX_LSB;
  assign req = '{adr: idx, dat: wb_dat_i[7:0], we: wb_we_i};
  assign wr_en = wb_cyc_i & wb_stb_i & ~wb_ack_o & req.we & wb_sel_i[0];
  assign rd_en = wb_cyc_i & wb_stb_i & ~wb_ack_o & ~req.we;

  function automatic logic hit(input logic [7:0] a, input logic [7:0] r);
    hit = (a == r);
  endfunction

  logic [7:0] status_q;
  logic [7:0] interrupt_control_q;
  logic [3:0] sp_q;
  logic [1:0] phase_q;
  logic       phase_two_pulse;
  logic       pin_q;
  logic       in_service_q;
  logic       halted_q;
  logic [2:0] wake_mask_q;
  logic [7:0] alu_a_q;
  logic [7:0] alu_b_q;
  logic [3:0] alu_op_q;
  logic       alu_go_q;
  logic [2:0] pend_q;
  logic       ev_wr;
  logic [7:0] ev;
  isf_pkg::isf_alu_s alu;

  assign ev_wr = wr_en & hit(req.adr, isf_pkg::ADDR_EVENT_IDX);
  assign ev = ev_wr ? req.dat : isf_pkg::RESET_ZERO;

  // Phase divider gives one-cycle phase-two enable
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      phase_q <= '0;
    end else begin
      phase_q <= phase_q + 2'h1;
    end
  end
  assign phase_two_pulse = (phase_q == isf_pkg::PHASE_LAST);

  // Pin history for edge detect; pin taken as synchronous
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      pin_q <= 1'b1;
    end else begin
      pin_q <= ext_irq_pin;
    end
  end

  // Source events and enabled-pending view
  logic [2:0] src_set;
  logic [2:0] ena;
  logic [2:0] flg;
  logic       stack_full;
  logic       take;
  logic [1:0] sel;
  assign src_set = {tmr1_ovf, tmr0_ovf, pin_q & ~ext_irq_pin}; // [R1] [R3]
  assign ena = {interrupt_control_q[isf_pkg::IC_T1E], interrupt_control_q[isf_pkg::IC_T0E],
                interrupt_control_q[isf_pkg::IC_EEN]};                       // [R11] [R4]
  assign flg = {interrupt_control_q[isf_pkg::IC_T1F], interrupt_control_q[isf_pkg::IC_T0F],
                interrupt_control_q[isf_pkg::IC_EF]};
  assign stack_full = (sp_q == isf_pkg::STACK_DEPTH);

  // Requests raised between phase pulses are latched on the next one, serviced on the second
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      pend_q <= '0;
    end else if (phase_two_pulse) begin
      pend_q <= flg & ena;                                      // [R9]
    end
  end

  // Only sources still flagged and enabled may win the priority pick
  logic [2:0] rdy;
  logic       pushing;
  logic       popping;
  assign rdy = pend_q & flg & ena;

  // Global enable gates all; full stack blocks acknowledge
  assign take = phase_two_pulse & interrupt_control_q[isf_pkg::IC_GIE] & ~stack_full
                & ~halted_q & |rdy;                             // [R5] [R10]
  assign sel = rdy[0] ? 2'd0 : rdy[1] ? 2'd1 : 2'd2;            // [R10]

  // One stack move a cycle; an empty stack is never popped
  assign pushing = (take | ev[isf_pkg::EV_CALL]) & ~stack_full; // [R6]
  assign popping = (ev[isf_pkg::EV_RET] | ev[isf_pkg::EV_RETURN_FROM_IRQ])
                   & (sp_q != 4'h0) & ~pushing;                  // [R8]

  // Interrupt control register; hardware set wins over clear
  logic [7:0] interrupt_control_d;
  always_comb begin
    interrupt_control_d = interrupt_control_q;
    if (wr_en && hit(req.adr, isf_pkg::ADDR_INTERRUPT_CONTROL_IDX)) begin
      interrupt_control_d = req.dat & isf_pkg::IC_WMASK;                     // [R13]
    end
    if (take) begin
      interrupt_control_d[isf_pkg::IC_GIE] = 1'b0;                           // [R2] [R7]
      interrupt_control_d[isf_pkg::IC_EF + 32'(sel)] = 1'b0;                 // [R2] [R3]
    end
    if (ev[isf_pkg::EV_RETURN_FROM_IRQ]) begin
      interrupt_control_d[isf_pkg::IC_GIE] = 1'b1;                           // [R8]
    end
    if (src_set[0]) interrupt_control_d[isf_pkg::IC_EF] = 1'b1;              // [R1] [R12]
    if (src_set[1]) interrupt_control_d[isf_pkg::IC_T0F] = 1'b1;             // [R3] [R12]
    if (src_set[2]) interrupt_control_d[isf_pkg::IC_T1F] = 1'b1;             // [R4] [R12]
  end

  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      interrupt_control_q <= isf_pkg::RESET_ZERO;                            // [R23]
    end else begin
      interrupt_control_q <= interrupt_control_d;
    end
  end

  // Stack level: entry and call push PC only, returns pop
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      sp_q <= '0;
    end else begin
      if (pushing) begin
        sp_q <= sp_q + 4'h1;                                    // [R6]
      end else if (popping) begin
        sp_q <= sp_q - 4'h1;                                    // [R8]
      end
    end
  end

  // Service flag: cleared by return or by software re-enable
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      in_service_q <= 1'b0;
    end else if (take) begin
      in_service_q <= 1'b1;
    end else if (ev[isf_pkg::EV_RETURN_FROM_IRQ] || interrupt_control_q[isf_pkg::IC_GIE]) begin
      in_service_q <= 1'b0;                                     // [R7]
    end
  end

  // Call strobe and vector to the sequencer
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      irq_call   <= 1'b0;
      irq_vector <= isf_pkg::RESET_ZERO;
      pc_push    <= 1'b0;
      pc_pop     <= 1'b0;
    end else begin
      irq_call <= take;
      pc_push  <= pushing;                                      // [R6]
      pc_pop   <= popping;                                      // [R8]
      if (take) begin
        case (sel)
          2'd0:    irq_vector <= isf_pkg::VEC_EXT;              // [R2]
          2'd1:    irq_vector <= isf_pkg::VEC_TMR0;             // [R3]
          default: irq_vector <= isf_pkg::VEC_TMR1;             // [R4]
        endcase
      end
    end
  end

  // Halt state and wake mask of flags already set at halt
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      halted_q    <= 1'b0;
      wake_mask_q <= '0;
      wake_req    <= 1'b0;
    end else begin
      wake_req <= halted_q & |(src_set & ~wake_mask_q);         // [R22]
      if (ev[isf_pkg::EV_HALT]) begin
        halted_q    <= 1'b1;
        wake_mask_q <= flg;                                     // [R22]
      end else if (ev[isf_pkg::EV_WAKE] || wake_req) begin
        halted_q <= 1'b0;
      end
    end
  end

  // ALU operand registers, written by software
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      alu_a_q  <= '0;
      alu_b_q  <= '0;
      alu_op_q <= '0;
      alu_go_q <= 1'b0;
    end else begin
      alu_go_q <= 1'b0;
      if (wr_en && hit(req.adr, isf_pkg::ADDR_ALU_IDX)) begin
        alu_a_q  <= wb_dat_i[7:0];
        alu_b_q  <= wb_dat_i[15:8];
        alu_op_q <= wb_dat_i[19:16];
        alu_go_q <= 1'b1;
      end
    end
  end

  // Eight-bit ALU with flag generation
  always_comb begin
    logic [8:0] s;
    logic [4:0] h;
    logic [8:0] d;
    logic       cin;
    s = '0;
    h = '0;
    d = '0;
    cin = status_q[isf_pkg::ST_C];
    alu.c  = status_q[isf_pkg::ST_C];
    alu.ac = status_q[isf_pkg::ST_AC];
    alu.ov = status_q[isf_pkg::ST_OV];
    case (isf_pkg::isf_op_e'(alu_op_q))
      isf_pkg::ISF_OP_ADD, isf_pkg::ISF_OP_ADC: begin
        s = {1'b0, alu_a_q} + {1'b0, alu_b_q}
            + {8'h00, alu_op_q == 4'(isf_pkg::ISF_OP_ADC) & cin};
        h = {1'b0, alu_a_q[3:0]} + {1'b0, alu_b_q[3:0]}
            + {4'h0, alu_op_q == 4'(isf_pkg::ISF_OP_ADC) & cin};
      end
      isf_pkg::ISF_OP_SUB, isf_pkg::ISF_OP_SBC: begin
        // No-borrow form: a plus not b plus carry-in
        s = {1'b0, alu_a_q} + {1'b0, ~alu_b_q}
            + {8'h00, alu_op_q == 4'(isf_pkg::ISF_OP_SUB) | cin};
        h = {1'b0, alu_a_q[3:0]} + {1'b0, ~alu_b_q[3:0]}
            + {4'h0, alu_op_q == 4'(isf_pkg::ISF_OP_SUB) | cin};
      end
      isf_pkg::ISF_OP_DAA: begin
        d = {1'b0, alu_a_q};
        if (d[3:0] > 4'h9 || status_q[isf_pkg::ST_AC]) d = d + 9'h006;
        if (d[8:4] > 5'h09 || cin) d = d + 9'h060;
        s = {d[8] | cin, d[7:0]};
      end
      isf_pkg::ISF_OP_AND: s = {cin, alu_a_q & alu_b_q};
      isf_pkg::ISF_OP_OR:  s = {cin, alu_a_q | alu_b_q};
      isf_pkg::ISF_OP_XOR: s = {cin, alu_a_q ^ alu_b_q};
      isf_pkg::ISF_OP_CPL: s = {cin, ~alu_a_q};
      isf_pkg::ISF_OP_RL:  s = {cin, alu_a_q[6:0], alu_a_q[7]};
      isf_pkg::ISF_OP_RR:  s = {cin, alu_a_q[0], alu_a_q[7:1]};
      isf_pkg::ISF_OP_RLC: s = {alu_a_q, cin};                  // [R15]
      isf_pkg::ISF_OP_RRC: s = {alu_a_q[0], cin, alu_a_q[7:1]}; // [R15]
      isf_pkg::ISF_OP_INC: s = {cin, alu_a_q + 8'h01};
      isf_pkg::ISF_OP_DEC: s = {cin, alu_a_q - 8'h01};
      default:             s = {cin, alu_a_q};
    endcase
    alu.res = s[7:0];
    alu.z   = (s[7:0] == 8'h00);                                // [R17]
    alu.c   = s[8];                                             // [R15] [R21]
    if (alu_op_q <= 4'(isf_pkg::ISF_OP_SBC)) begin
      alu.ac = h[4];                                            // [R16]
      alu.ov = s[8] ^ (alu_a_q[7] ^ (alu_op_q >= 4'(isf_pkg::ISF_OP_SUB)
               ? ~alu_b_q[7] : alu_b_q[7]) ^ s[7]);             // [R18]
    end
  end

  // Status: writes touch only the ALU flags
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      status_q <= isf_pkg::RESET_ZERO;                          // [R19] [R20]
    end else begin
      if (wr_en && hit(req.adr, isf_pkg::ADDR_STATUS_IDX)) begin
        status_q <= (status_q & ~isf_pkg::ST_WMASK)
                    | (req.dat & isf_pkg::ST_WMASK);            // [R14]
      end else if (alu_go_q) begin
        status_q[isf_pkg::ST_C]  <= alu.c;
        status_q[isf_pkg::ST_AC] <= alu.ac;
        status_q[isf_pkg::ST_Z]  <= alu.z;
        status_q[isf_pkg::ST_OV] <= alu.ov;
      end
      if (ev[isf_pkg::EV_HALT]) begin
        status_q[isf_pkg::ST_PD] <= 1'b1;                       // [R19]
        status_q[isf_pkg::ST_TO] <= 1'b0;                       // [R20]
      end else if (ev[isf_pkg::EV_WDCLR]) begin
        status_q[isf_pkg::ST_PD] <= 1'b0;                       // [R19]
        status_q[isf_pkg::ST_TO] <= 1'b0;                       // [R20]
      end else if (ev[isf_pkg::EV_WDTO]) begin
        status_q[isf_pkg::ST_TO] <= 1'b1;                       // [R20]
      end
    end
  end

  // ALU result held for readback
  logic [7:0] res_q;
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      res_q <= '0;
    end else if (alu_go_q) begin
      res_q <= alu.res;                                         // [R21]
    end
  end

  // Wishbone slave: one-cycle ack, unmapped reads zero
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= '0;
    end else begin
      wb_ack_o <= wb_cyc_i & wb_stb_i & ~wb_ack_o;
      if (rd_en) begin
        case (req.adr)
          isf_pkg::ADDR_STATUS_IDX: wb_dat_o <= {24'h0, status_q};
          isf_pkg::ADDR_INTERRUPT_CONTROL_IDX:   wb_dat_o <= {24'h0, interrupt_control_q};
          isf_pkg::ADDR_CORE_IDX:   wb_dat_o <= {24'h0, in_service_q,
                                      halted_q, 2'h0, sp_q};
          isf_pkg::ADDR_RES_IDX:    wb_dat_o <= {24'h0, res_q};
          default:                  wb_dat_o <= '0;
        endcase
      end
    end
  end

  // Outputs of an external entry, one cycle after it is taken
  sequence s_ext_entry;
    irq_call && pc_push && irq_vector == isf_pkg::VEC_EXT;
  endsequence

  // Entry clears global enable in the next cycle
  a_entry_clears_gie: assert property ( // [R2]
    @(posedge sys_clk) disable iff (!arst_n)
    take |=> !interrupt_control_q[isf_pkg::IC_GIE]) else $error("gie kept");
  // Full stack: no entry strobe and no push reach the sequencer
  a_full_blocks: assert property ( // [R5]
    @(posedge sys_clk) disable iff (!arst_n)
    stack_full |=> !irq_call && !pc_push) else $error("entry on full stack");
  // Entry only on a phase pulse
  a_phase_only: assert property ( // [R9]
    @(posedge sys_clk) disable iff (!arst_n)
    take |-> phase_two_pulse) else $error("off phase entry");
  // Falling pin edge sets flag
  a_edge_sets: assert property ( // [R1]
    @(posedge sys_clk) disable iff (!arst_n)
    $fell(ext_irq_pin) |=> interrupt_control_q[isf_pkg::IC_EF]) else $error("no flag");
  // Return-from-irq restores global enable
  a_return_from_irq_gie: assert property ( // [R8]
    @(posedge sys_clk) disable iff (!arst_n)
    ev[isf_pkg::EV_RETURN_FROM_IRQ] |=> interrupt_control_q[isf_pkg::IC_GIE]) else $error("no gie");
  // Top bit never set
  a_bit7_zero: assert property ( // [R13]
    @(posedge sys_clk) disable iff (!arst_n)
    !interrupt_control_q[7] && status_q[7:6] == 2'h0) else $error("reserved set");
  // Halt sets powerdown and clears timeout
  a_halt_flags: assert property ( // [R19]
    @(posedge sys_clk) disable iff (!arst_n)
    ev[isf_pkg::EV_HALT] |=> status_q[isf_pkg::ST_PD] &&
    !status_q[isf_pkg::ST_TO]) else $error("halt flags");
  // Vector follows external priority
  a_ext_vector: assert property ( // [R10]
    @(posedge sys_clk) disable iff (!arst_n)
    take && sel == 2'd0 |=> s_ext_entry) else $error("bad vector");
endmodule

// ===== hw/isf_pkg.sv
package isf_pkg;
  // Register indices; byte address is index times four
  localparam logic [7:0] ADDR_STATUS_IDX = 8'h0a;
  localparam logic [7:0] ADDR_INTERRUPT_CONTROL_IDX   = 8'h0b;
  localparam logic [7:0] ADDR_CORE_IDX   = 8'h0c;
  localparam logic [7:0] ADDR_EVENT_IDX  = 8'h0d;
  localparam logic [7:0] ADDR_ALU_IDX    = 8'h0e;
  localparam logic [7:0] ADDR_RES_IDX    = 8'h0f;
  localparam int         IDX_LSB         = 2;
  // Status bits
  localparam int ST_C   = 0;
  localparam int ST_AC  = 1;
  localparam int ST_Z   = 2;
  localparam int ST_OV  = 3;
  localparam int ST_PD  = 4;
  localparam int ST_TO  = 5;
  localparam logic [7:0] ST_WMASK = 8'h0f;
  // Interrupt control bits
  localparam int IC_GIE = 0;
  localparam int IC_EEN = 1;
  localparam int IC_T0E = 2;
  localparam int IC_T1E = 3;
  localparam int IC_EF  = 4;
  localparam int IC_T0F = 5;
  localparam int IC_T1F = 6;
  localparam logic [7:0] IC_WMASK = 8'h7f;
  localparam logic [7:0] RESET_ZERO = 8'h00;
  // Vectors
  localparam logic [7:0] VEC_EXT  = 8'h04;
  localparam logic [7:0] VEC_TMR0 = 8'h08;
  localparam logic [7:0] VEC_TMR1 = 8'h0c;
  // Stack depth for the largest family member
  localparam logic [3:0] STACK_DEPTH = 4'h8;
  // Phase pulse divider: one phase-two pulse every four clocks
  localparam logic [1:0] PHASE_LAST = 2'h3;
  // Event register bits (write one to fire)
  localparam int EV_CALL  = 0;
  localparam int EV_RET   = 1;
  localparam int EV_RETURN_FROM_IRQ  = 2;
  localparam int EV_HALT  = 3;
  localparam int EV_WDCLR = 4;
  localparam int EV_WDTO  = 5;
  localparam int EV_WAKE  = 6;

  typedef enum logic [3:0] {
    ISF_OP_ADD, ISF_OP_ADC, ISF_OP_SUB, ISF_OP_SBC, ISF_OP_DAA,
    ISF_OP_AND, ISF_OP_OR, ISF_OP_XOR, ISF_OP_CPL, ISF_OP_RL,
    ISF_OP_RR, ISF_OP_RLC, ISF_OP_RRC, ISF_OP_INC, ISF_OP_DEC
  } isf_op_e;

  typedef struct packed {
    logic [7:0] adr;
    logic [7:0] dat;
    logic       we;
  } isf_req_s;

  typedef struct packed {
    logic [7:0] res;
    logic       c;
    logic       ac;
    logic       z;
    logic       ov;
  } isf_alu_s;
endpackage

// ===== tb/isf_far_model.sv
`timescale 1ns/1ps
// Far side: timers, external pin driver and a mirror of the stack depth
module isf_far_model (
  input  wire logic       sys_clk,
  input  wire logic       arst_n,
  input  wire logic       fire_ext,
  input  wire logic       fire_t0,
  input  wire logic       fire_t1,
  input  wire logic       pc_push,
  input  wire logic       pc_pop,
  output logic            ext_irq_pin,
  output logic            tmr0_ovf,
  output logic            tmr1_ovf,
  output logic      [3:0] depth_q
);
  logic fire_d_q;

  // Pin idles high; a request pulls it low for two clocks
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      fire_d_q    <= 1'b0;
      ext_irq_pin <= 1'b1;
    end else begin
      fire_d_q    <= fire_ext;
      ext_irq_pin <= !(fire_ext || fire_d_q);
    end
  end

  // Overflow lasts one clock, as a real counter wrap would
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      tmr0_ovf <= 1'b0;
      tmr1_ovf <= 1'b0;
    end else begin
      tmr0_ovf <= fire_t0;
      tmr1_ovf <= fire_t1;
    end
  end

  // Only the return address goes on the stack, so one entry a push
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      depth_q <= 4'h0;
    end else begin
      depth_q <= depth_q + {3'h0, pc_push} - {3'h0, pc_pop};
    end
  end
endmodule

// ===== tb/testbench.sv
`timescale 1ns/1ps
module testbench;
  logic        sys_clk;
  logic        arst_n;
  logic [7:0]  adr;
  logic [31:0] wdat;
  logic [31:0] rdat;
  logic        we;
  logic [3:0]  sel;
  logic        cyc;
  logic        stb;
  logic        ack;
  logic        pin;
  logic        t0_ovf;
  logic        t1_ovf;
  logic        call;
  logic [7:0]  vec;
  logic        push;
  logic        pop;
  logic        wake;
  logic        f_ext;
  logic        f_t0;
  logic        f_t1;
  logic [3:0]  depth;
  logic [7:0]  q;
  logic [19:0] alu_in [7];
  logic [7:0]  alu_res [7];
  logic [7:0]  alu_st [7];
  logic [7:0]  alu_msk [7];
  int          fail_count;
  int          check_count;

  isf_core u_dut (.sys_clk(sys_clk), .arst_n(arst_n), .wb_adr_i(adr),
    .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_we_i(we), .wb_sel_i(sel),
    .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_ack_o(ack), .ext_irq_pin(pin),
    .tmr0_ovf(t0_ovf), .tmr1_ovf(t1_ovf), .irq_call(call),
    .irq_vector(vec), .pc_push(push), .pc_pop(pop), .wake_req(wake));

  isf_far_model u_far (.sys_clk(sys_clk), .arst_n(arst_n),
    .fire_ext(f_ext), .fire_t0(f_t0), .fire_t1(f_t1), .pc_push(push),
    .pc_pop(pop), .ext_irq_pin(pin), .tmr0_ovf(t0_ovf),
    .tmr1_ovf(t1_ovf), .depth_q(depth));

  // Free-running 25 MHz clock
  initial begin
    sys_clk = 1'b0;
    forever #20 sys_clk = ~sys_clk;
  end

  task automatic stop_test;
    $display("checks %0d, mismatches %0d", check_count, fail_count);
    if (fail_count == 0 && check_count > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask

  task automatic check(input logic [7:0] got, input logic [7:0] exp);
    check_count++;
    if (got !== exp) begin
      fail_count++;
      $display("ERROR at %0t: saw %h, expected %h", $time, got, exp);
    end
  endtask

  // One classic cycle; no latency assumed, only a bounded wait for ack
  task automatic wb(input logic [7:0] idx, input logic w,
                    input logic [31:0] d, output logic [7:0] r);
    int n;
    n = 0;
    @(posedge sys_clk);
    adr  <= idx << isf_pkg::IDX_LSB;
    we   <= w;
    wdat <= d;
    sel  <= 4'hf;
    cyc  <= 1'b1;
    stb  <= 1'b1;
    do begin
      @(posedge sys_clk);
      n++;
    end while (ack !== 1'b1 && n < 20);
    r = rdat[7:0];
    cyc <= 1'b0;
    stb <= 1'b0;
    we  <= 1'b0;
    if (ack !== 1'b1) begin
      fail_count++;
      stop_test();
    end
  endtask

  task automatic wr(input logic [7:0] idx, input logic [31:0] d);
    logic [7:0] r;
    wb(idx, 1'b1, d, r);
  endtask

  task automatic rdchk(input logic [7:0] idx, input logic [7:0] exp);
    logic [7:0] r;
    wb(idx, 1'b0, 32'h0, r);
    check(r, exp);
  endtask

  task automatic ev(input int b);
    wr(isf_pkg::ADDR_EVENT_IDX, 32'h1 << b);
  endtask

  // Asks the far side for one event: 0 pin, 1 timer 0, 2 timer 1
  task automatic fire(input int which);
    @(posedge sys_clk);
    f_ext <= (which == 0);
    f_t0  <= (which == 1);
    f_t1  <= (which == 2);
    @(posedge sys_clk);
    f_ext <= 1'b0;
    f_t0  <= 1'b0;
    f_t1  <= 1'b0;
    repeat (3) @(posedge sys_clk);
  endtask

  // Entry must come within a few phase pulses, with a push beside it
  task automatic call_chk(input logic [7:0] exp);
    int n;
    n = 0;
    do begin
      @(posedge sys_clk);
      n++;
    end while (call !== 1'b1 && n < 40);
    check({6'h0, call, push}, 8'h03);
    check(vec, exp);
  endtask

  task automatic no_call;
    logic seen;
    seen = 1'b0;
    repeat (40) begin
      @(posedge sys_clk);
      if (call === 1'b1) seen = 1'b1;
    end
    check({7'h0, seen}, 8'h00);
  endtask

  // Watches the wake strobe, a one-cycle pulse, over a window
  task automatic wake_chk(input logic [7:0] exp);
    logic seen;
    seen = 1'b0;
    repeat (20) begin
      @(posedge sys_clk);
      if (wake === 1'b1) seen = 1'b1;
    end
    check({7'h0, seen}, exp);
  endtask

  initial begin
    #2000000;
    fail_count++;
    stop_test();
  end

  // Main sequence
  initial begin
    fail_count = 0;
    check_count = 0;
    arst_n = 1'b0;
    {adr, wdat, we, sel, cyc, stb, f_ext, f_t0, f_t1} = '0;
    alu_in  = '{20'h0010f, 20'h08080, 20'h20505, 20'h50ff0, 20'hd00ff,
                20'hb0001, 20'h30110};
    alu_res = '{8'h10, 8'h00, 8'h00, 8'h00, 8'h00, 8'h03, 8'h0e};
    alu_st  = '{8'h02, 8'h0d, 8'h07, 8'h05, 8'h04, 8'h00, 8'h01};
    alu_msk = '{8'h0f, 8'h0f, 8'h0f, 8'h05, 8'h04, 8'h05, 8'h0f};
    repeat (3) @(posedge sys_clk);
    arst_n <= 1'b1;
    rdchk(isf_pkg::ADDR_INTERRUPT_CONTROL_IDX, 8'h00);
    rdchk(isf_pkg::ADDR_STATUS_IDX, 8'h00);
    rdchk(8'h20, 8'h00);
    wr(isf_pkg::ADDR_INTERRUPT_CONTROL_IDX, 32'hf0);
    rdchk(isf_pkg::ADDR_INTERRUPT_CONTROL_IDX, 8'h70);
    wr(isf_pkg::ADDR_INTERRUPT_CONTROL_IDX, 32'h00);
    rdchk(isf_pkg::ADDR_INTERRUPT_CONTROL_IDX, 8'h00);
    // External request recorded while masked, then taken
    fire(0);
    rdchk(isf_pkg::ADDR_INTERRUPT_CONTROL_IDX, 8'h10);
    repeat (20) @(posedge sys_clk);
    rdchk(isf_pkg::ADDR_INTERRUPT_CONTROL_IDX, 8'h10);
    wr(isf_pkg::ADDR_INTERRUPT_CONTROL_IDX, 32'h13);
    call_chk(isf_pkg::VEC_EXT);
    rdchk(isf_pkg::ADDR_INTERRUPT_CONTROL_IDX, 8'h02);
    ev(isf_pkg::EV_RETURN_FROM_IRQ);
    rdchk(isf_pkg::ADDR_INTERRUPT_CONTROL_IDX, 8'h03);
    // Timer 0 flag with its enable off stays unserved
    fire(1);
    no_call();
    rdchk(isf_pkg::ADDR_INTERRUPT_CONTROL_IDX, 8'h23);
    // Two pending at once: external goes first
    wr(isf_pkg::ADDR_INTERRUPT_CONTROL_IDX, 32'h37);
    call_chk(isf_pkg::VEC_EXT);
    rdchk(isf_pkg::ADDR_INTERRUPT_CONTROL_IDX, 8'h26);
    ev(isf_pkg::EV_RETURN_FROM_IRQ);
    call_chk(isf_pkg::VEC_TMR0);
    rdchk(isf_pkg::ADDR_INTERRUPT_CONTROL_IDX, 8'h06);
    check({4'h0, depth}, 8'h01);
    ev(isf_pkg::EV_RET);
    rdchk(isf_pkg::ADDR_INTERRUPT_CONTROL_IDX, 8'h06);
    check({4'h0, depth}, 8'h00);
    // Timer 1 behaves like timer 0
    wr(isf_pkg::ADDR_INTERRUPT_CONTROL_IDX, 32'h00);
    fire(2);
    rdchk(isf_pkg::ADDR_INTERRUPT_CONTROL_IDX, 8'h40);
    wr(isf_pkg::ADDR_INTERRUPT_CONTROL_IDX, 32'h49);
    call_chk(isf_pkg::VEC_TMR1);
    rdchk(isf_pkg::ADDR_INTERRUPT_CONTROL_IDX, 8'h08);
    ev(isf_pkg::EV_RETURN_FROM_IRQ);
    rdchk(isf_pkg::ADDR_INTERRUPT_CONTROL_IDX, 8'h09);
    // Full stack holds off entry until a pop
    wr(isf_pkg::ADDR_INTERRUPT_CONTROL_IDX, 32'h00);
    repeat (8) ev(isf_pkg::EV_CALL);
    wb(isf_pkg::ADDR_CORE_IDX, 1'b0, 32'h0, q);
    check(q & 8'h0f, 8'h08);
    check({4'h0, depth}, 8'h08);
    wr(isf_pkg::ADDR_INTERRUPT_CONTROL_IDX, 32'h25);
    no_call();
    rdchk(isf_pkg::ADDR_INTERRUPT_CONTROL_IDX, 8'h25);
    ev(isf_pkg::EV_RET);
    call_chk(isf_pkg::VEC_TMR0);
    wr(isf_pkg::ADDR_INTERRUPT_CONTROL_IDX, 32'h00);
    // Arithmetic flags from a table of operations
    for (int i = 0; i < 7; i++) begin
      wr(isf_pkg::ADDR_ALU_IDX, {12'h0, alu_in[i]});
      rdchk(isf_pkg::ADDR_RES_IDX, alu_res[i]);
      wb(isf_pkg::ADDR_STATUS_IDX, 1'b0, 32'h0, q);
      check(q & alu_msk[i], alu_st[i]);
    end
    // Power-down and time-out flags move only on their events
    wr(isf_pkg::ADDR_STATUS_IDX, 32'hff);
    rdchk(isf_pkg::ADDR_STATUS_IDX, 8'h0f);
    ev(isf_pkg::EV_HALT);
    rdchk(isf_pkg::ADDR_STATUS_IDX, 8'h1f);
    ev(isf_pkg::EV_WDTO);
    rdchk(isf_pkg::ADDR_STATUS_IDX, 8'h3f);
    wr(isf_pkg::ADDR_STATUS_IDX, 32'h00);
    rdchk(isf_pkg::ADDR_STATUS_IDX, 8'h30);
    ev(isf_pkg::EV_WDCLR);
    rdchk(isf_pkg::ADDR_STATUS_IDX, 8'h00);
    // Still halted: a fresh source wakes, one pending at halt does not
    fork
      fire(1);
      wake_chk(8'h01);
    join
    ev(isf_pkg::EV_HALT);
    fork
      fire(1);
      wake_chk(8'h00);
    join
    stop_test();
  end
endmodule
